// File: hdl/fpa_pkg.sv
/*
  Package for the front panel and power annunciator: timing constants,
  beep pattern encodings, lamp modes and grouped status carriers.
  Assumes a 100 MHz system clock.
*/
package fpa_pkg;

    // ----------------
    // Timing
    // ----------------
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned DISTRESS_HOLD_S = 5;
    localparam int unsigned DISTRESS_HOLD_CYC = DISTRESS_HOLD_S * CLK_HZ;
    localparam int unsigned BLINK_HALF_MS = 250;
    localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);
    localparam int unsigned BEEP_FAST_MS = 60;
    localparam int unsigned BEEP_FAST_CYC = BEEP_FAST_MS * (CLK_HZ / 1000);
    localparam int unsigned BEEP_NORM_MS = 200;
    localparam int unsigned BEEP_NORM_CYC = BEEP_NORM_MS * (CLK_HZ / 1000);

    // ----------------
    // Beep counts and serial defaults
    // ----------------
    localparam logic [2:0] BEEPS_DISTRESS_RX = 3'h4;
    localparam logic [2:0] BEEPS_PRINTER_ERR = 3'h2;
    localparam logic [2:0] BEEPS_ONE = 3'h1;
    localparam logic [2:0] BEEPS_POS_FIX = 3'h2;
    localparam logic [15:0] SER_DEF_BAUD = 16'h12c0;
    localparam logic [3:0] SER_DEF_DATA_BITS = 4'h8;
    localparam logic SER_DEF_PARITY_EN = 1'b0;
    localparam logic [1:0] SER_DEF_STOP_BITS = 2'h1;

    // ----------------
    // Types
    // ----------------
    typedef enum logic [1:0] {
        FPA_LAMP_OFF,
        FPA_LAMP_ON,
        FPA_LAMP_BLINK
    } fpa_lamp_type;

    typedef struct packed {
        logic [15:0] baud;
        logic [3:0] data_bits;
        logic parity_en;
        logic [1:0] stop_bits;
    } fpa_serial_cfg_type;

    typedef struct packed {
        logic beep_req;
        logic fast;
        logic [2:0] count;
    } fpa_beep_req_type;

    typedef struct packed {
        logic login;
        logic send;
        logic mail;
        logic alarm;
    } fpa_lamps_type;

endpackage

// File: hdl/fpa_beeper.sv
/*
  Beep pattern sequencer: plays a burst of N beeps, fast or normal.
  Assumes requests are single-cycle pulses; a request while busy is dropped.
*/
`timescale 1ns/1ps
module fpa_beeper #(
    parameter int unsigned FAST_CYC = fpa_pkg::BEEP_FAST_CYC,
    parameter int unsigned NORM_CYC = fpa_pkg::BEEP_NORM_CYC
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Request
    input wire fpa_pkg::fpa_beep_req_type req_i,
    output logic busy_o,
    // Speaker
    output logic speaker_o
);

    typedef enum logic [1:0] {
        FPA_BP_IDLE,
        FPA_BP_TONE,
        FPA_BP_GAP
    } fpa_bp_state_type;

    fpa_bp_state_type state_r;
    logic [31:0] tmr_r;
    logic [2:0] left_r;
    logic fast_r;
    logic [31:0] len;

    // Fast beeps use the shorter tone and gap
    assign len = fast_r ? 32'(FAST_CYC) : 32'(NORM_CYC); // R21
    assign busy_o = (state_r != FPA_BP_IDLE);

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            state_r <= FPA_BP_IDLE;
            tmr_r <= 32'h0;
            left_r <= 3'h0;
            fast_r <= 1'b0;
            speaker_o <= 1'b0;
        end
        else if (ce_i)
        begin
            case (state_r)
                FPA_BP_IDLE:
                begin
                    speaker_o <= 1'b0;
                    if (req_i.beep_req && req_i.count != 3'h0)
                    begin
                        state_r <= FPA_BP_TONE;
                        left_r <= req_i.count;
                        fast_r <= req_i.fast;
                        tmr_r <= 32'h0;
                        speaker_o <= 1'b1;
                    end
                end
                FPA_BP_TONE:
                begin
                    if (tmr_r >= len - 32'h1)
                    begin
                        tmr_r <= 32'h0;
                        speaker_o <= 1'b0;
                        left_r <= left_r - 3'h1;
                        state_r <= FPA_BP_GAP;
                    end
                    else
                    begin
                        tmr_r <= tmr_r + 32'h1;
                    end
                end
                FPA_BP_GAP:
                begin
                    if (tmr_r >= len - 32'h1)
                    begin
                        tmr_r <= 32'h0;
                        if (left_r == 3'h0)
                        begin
                            state_r <= FPA_BP_IDLE;
                        end
                        else
                        begin
                            speaker_o <= 1'b1;
                            state_r <= FPA_BP_TONE;
                        end
                    end
                    else
                    begin
                        tmr_r <= tmr_r + 32'h1;
                    end
                end
                default:
                begin
                    state_r <= FPA_BP_IDLE;
                    speaker_o <= 1'b0;
                end
            endcase
        end
    end

endmodule // fpa_beeper

// File: hdl/fpa_button_hold.sv
/*
  Hold detector: pulses once when a level has stood high for HOLD_CYC cycles.
  Assumes the input is already synchronous and debounced.
*/
`timescale 1ns/1ps
module fpa_button_hold #(
    parameter int unsigned HOLD_CYC = fpa_pkg::DISTRESS_HOLD_CYC
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Level in, pulse out
    input wire logic level_i,
    output logic held_o
);

    logic [31:0] cnt_r;
    logic fired_r;

    // A single pulse per hold; releasing the buttons re-arms it
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            cnt_r <= 32'h0;
            fired_r <= 1'b0;
            held_o <= 1'b0;
        end
        else if (ce_i)
        begin
            held_o <= 1'b0;
            if (!level_i)
            begin
                cnt_r <= 32'h0;
                fired_r <= 1'b0;
            end
            else if (!fired_r)
            begin
                if (cnt_r >= 32'(HOLD_CYC) - 32'h1)
                begin
                    held_o <= 1'b1;
                    fired_r <= 1'b1;
                end
                else
                begin
                    cnt_r <= cnt_r + 32'h1;
                end
            end
        end
    end

endmodule // fpa_button_hold

// File: hdl/fpa_annunciator.sv
/*
  Front panel and power annunciator: lamps, speaker patterns, set/alarm
  button decode, power-on resolution and antenna supply selection.
  Assumes all inputs are synchronous to sys_clk_i and event inputs are
  single-cycle pulses from the protocol engine.
*/
`timescale 1ns/1ps

// Contract
// R01 - Urgent/distress broadcast or distress alert message gives four fast beeps
// R02 - Printer error gives two normal beeps
// R03 - Bell character in printed message gives one normal beep
// R04 - New transmission start gives one normal beep unless silent
// R05 - Distress alert start gives one normal beep
// R06 - Distress acknowledgement gives one normal beep unless silent
// R07 - First position fix after power-on gives two fast beeps
// R08 - Set held at power-on loads 4800 baud, 8 bits, no parity, 1 stop
// R09 - Set press after power-on leaves serial settings alone
// R10 - Login lamp steady when logged in, blinks when synced, dark otherwise
// R11 - Send lamp blinks in protocol, steady transmitting, blinks awaiting ack
// R12 - Mail lamp blinks while receiving, steady until message read
// R13 - Set plus alarm held five seconds starts distress alert
// R14 - Alarm lamp dark, blinks after alert until ack, then steady
// R15 - Open remote line is off, line shorted to negative is on
// R16 - Master off forces off; else remote or timer gives on
// R17 - Wake-up timer switches unit back on after programmed interval
// R18 - Antenna supply high when transmitting, selected level when receiving
// R19 - Receive supply defaults high; low and high commands select it
// R20 - Power lamp lit whenever DC supply present
// R21 - Blink and beep timings are parameters with distinct fast and normal
module fpa_annunciator #(
    parameter int unsigned HOLD_CYC = fpa_pkg::DISTRESS_HOLD_CYC,
    parameter int unsigned BLINK_CYC = fpa_pkg::BLINK_HALF_CYC,
    parameter int unsigned FAST_CYC = fpa_pkg::BEEP_FAST_CYC,
    parameter int unsigned NORM_CYC = fpa_pkg::BEEP_NORM_CYC,
    parameter int unsigned WAKE_W = 32
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Power inputs
    input wire logic dc_present_i,
    input wire logic master_power_switch_i,
    input wire logic remote_line_shorted_i,
    // Wake-up timer control
    input wire logic sleep_req_i,
    input wire logic [WAKE_W-1:0] wake_interval_i,
    // Buttons
    input wire logic set_button_i,
    input wire logic alarm_button_i,
    // Protocol engine events (pulses)
    input wire logic egc_urgent_rx_i,
    input wire logic printer_error_i,
    input wire logic print_bell_i,
    input wire logic tx_start_i,
    input wire logic distress_ack_i,
    input wire logic pos_fix_i,
    // Protocol engine status (levels and pulses)
    input wire logic silent_mode_i,
    input wire logic synced_i,
    input wire logic logged_in_i,
    input wire logic tx_protocol_i,
    input wire logic transmitting_i,
    input wire logic land_earth_station_ack_i,
    input wire logic mail_incoming_i,
    input wire logic mail_received_i,
    input wire logic mail_read_i,
    // Antenna commands
    input wire logic ant_volt_low_cmd_i,
    input wire logic ant_volt_high_cmd_i,
    // Power, serial and distress outputs
    output logic unit_on_o,
    output logic ser_default_load_o,
    output fpa_pkg::fpa_serial_cfg_type ser_default_cfg_o,
    output logic distress_start_o,
    // Antenna supply
    output logic ant_supply_tx_o,
    output logic ant_supply_rx_high_o,
    // Front panel
    output logic power_lamp_o,
    output fpa_pkg::fpa_lamps_type lamps_o,
    output logic speaker_o
);

    // ----------------
    // Power-on resolution
    // ----------------
    logic timer_on_r;
    logic [WAKE_W-1:0] wake_cnt_r;
    logic unit_on;
    logic unit_on_d_r;
    logic power_up;

    // The line reads as on only when strapped to the supply negative
    assign unit_on = master_power_switch_i
                   && (remote_line_shorted_i || timer_on_r); // R15 R16
    assign power_up = unit_on && !unit_on_d_r;

    // Battery-backed timer: counts down while asleep, then wakes the unit
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            timer_on_r <= 1'b0;
            wake_cnt_r <= '0;
        end
        else if (ce_i)
        begin
            if (sleep_req_i)
            begin
                timer_on_r <= 1'b0;
                wake_cnt_r <= wake_interval_i;
            end
            else if (!timer_on_r && wake_cnt_r != '0)
            begin
                wake_cnt_r <= wake_cnt_r - 1'b1;
                if (wake_cnt_r == {{(WAKE_W-1){1'b0}}, 1'b1})
                begin
                    timer_on_r <= 1'b1; // R17
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            unit_on_d_r <= 1'b0;
            unit_on_o <= 1'b0;
            power_lamp_o <= 1'b0;
        end
        else if (ce_i)
        begin
            unit_on_d_r <= unit_on;
            unit_on_o <= unit_on;
            power_lamp_o <= dc_present_i; // R20
        end
    end

    // ----------------
    // Set button and serial defaults
    // ----------------
    // Sampled only on the power-up edge so later presses do nothing
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            ser_default_load_o <= 1'b0;
            ser_default_cfg_o <= '0;
        end
        else if (ce_i)
        begin
            ser_default_load_o <= power_up && set_button_i; // R08 R09
            ser_default_cfg_o.baud <= fpa_pkg::SER_DEF_BAUD; // R08
            ser_default_cfg_o.data_bits <= fpa_pkg::SER_DEF_DATA_BITS;
            ser_default_cfg_o.parity_en <= fpa_pkg::SER_DEF_PARITY_EN;
            ser_default_cfg_o.stop_bits <= fpa_pkg::SER_DEF_STOP_BITS;
        end
    end

    // ----------------
    // Distress trigger
    // ----------------
    logic distress_hold;

    fpa_button_hold #(
        .HOLD_CYC(HOLD_CYC)
    ) u_hold (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .level_i(set_button_i && alarm_button_i && unit_on_o), // R13
        .held_o(distress_hold)
    );

    assign distress_start_o = distress_hold;

    // ----------------
    // Blink and lamp states
    // ----------------
    logic [31:0] blink_cnt_r;
    logic blink_r;
    logic send_ack_wait_r;
    logic mail_blink_r;
    logic mail_steady_r;
    logic alarm_wait_r;
    logic alarm_acked_r;
    logic tx_d_r;

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            blink_cnt_r <= 32'h0;
            blink_r <= 1'b0;
        end
        else if (ce_i)
        begin
            if (blink_cnt_r >= 32'(BLINK_CYC) - 32'h1) // R21
            begin
                blink_cnt_r <= 32'h0;
                blink_r <= !blink_r;
            end
            else
            begin
                blink_cnt_r <= blink_cnt_r + 32'h1;
            end
        end
    end

    // Send: wait-for-ack follows the end of transmitting
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            tx_d_r <= 1'b0;
            send_ack_wait_r <= 1'b0;
        end
        else if (ce_i)
        begin
            tx_d_r <= transmitting_i;
            if (tx_d_r && !transmitting_i)
            begin
                send_ack_wait_r <= 1'b1; // R11
            end
            else if (land_earth_station_ack_i || transmitting_i)
            begin
                send_ack_wait_r <= 1'b0;
            end
        end
    end

    // Mail: completion wins over a read in the same cycle
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            mail_blink_r <= 1'b0;
            mail_steady_r <= 1'b0;
        end
        else if (ce_i)
        begin
            if (mail_received_i)
            begin
                mail_blink_r <= 1'b0;
                mail_steady_r <= 1'b1; // R12
            end
            else
            begin
                if (mail_incoming_i)
                begin
                    mail_blink_r <= 1'b1; // R12
                end
                if (mail_read_i)
                begin
                    mail_steady_r <= 1'b0;
                end
            end
        end
    end

    // Alarm: blinking after the alert, steady once acknowledged
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            alarm_wait_r <= 1'b0;
            alarm_acked_r <= 1'b0;
        end
        else if (ce_i)
        begin
            if (distress_hold)
            begin
                alarm_wait_r <= 1'b1; // R14
                alarm_acked_r <= 1'b0;
            end
            else if (distress_ack_i && alarm_wait_r)
            begin
                alarm_wait_r <= 1'b0;
                alarm_acked_r <= 1'b1; // R14
            end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            lamps_o <= '0;
        end
        else if (ce_i)
        begin
            lamps_o.login <= logged_in_i || (synced_i && blink_r); // R10
            lamps_o.send <= transmitting_i
                || ((tx_protocol_i || send_ack_wait_r) && blink_r); // R11
            lamps_o.mail <= mail_steady_r || (mail_blink_r && blink_r); // R12
            lamps_o.alarm <= alarm_acked_r || (alarm_wait_r && blink_r); // R14
        end
    end

    // ----------------
    // Antenna supply
    // ----------------
    logic ant_rx_high_r;

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            ant_rx_high_r <= 1'b1; // R19
            ant_supply_tx_o <= 1'b0;
            ant_supply_rx_high_o <= 1'b1;
        end
        else if (ce_i)
        begin
            if (ant_volt_high_cmd_i)
            begin
                ant_rx_high_r <= 1'b1; // R19
            end
            else if (ant_volt_low_cmd_i)
            begin
                ant_rx_high_r <= 1'b0; // R19
            end
            ant_supply_tx_o <= transmitting_i; // R18
            ant_supply_rx_high_o <= ant_rx_high_r; // R18
        end
    end

    // ----------------
    // Speaker patterns
    // ----------------
    logic fix_seen_r;
    fpa_pkg::fpa_beep_req_type beep_req;

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            fix_seen_r <= 1'b0;
        end
        else if (ce_i)
        begin
            if (pos_fix_i)
            begin
                fix_seen_r <= 1'b1;
            end
            else if (power_up)
            begin
                fix_seen_r <= 1'b0;
            end
        end
    end

    // Highest urgency first; a lower event in the same cycle is dropped
    always_comb
    begin
        beep_req = '0;
        if (egc_urgent_rx_i)
        begin
            beep_req = '{1'b1, 1'b1, fpa_pkg::BEEPS_DISTRESS_RX}; // R01
        end
        else if (distress_hold)
        begin
            beep_req = '{1'b1, 1'b0, fpa_pkg::BEEPS_ONE}; // R05
        end
        else if (distress_ack_i && !silent_mode_i)
        begin
            beep_req = '{1'b1, 1'b0, fpa_pkg::BEEPS_ONE}; // R06
        end
        else if (printer_error_i)
        begin
            beep_req = '{1'b1, 1'b0, fpa_pkg::BEEPS_PRINTER_ERR}; // R02
        end
        else if (print_bell_i)
        begin
            beep_req = '{1'b1, 1'b0, fpa_pkg::BEEPS_ONE}; // R03
        end
        else if (tx_start_i && !silent_mode_i)
        begin
            beep_req = '{1'b1, 1'b0, fpa_pkg::BEEPS_ONE}; // R04
        end
        else if (pos_fix_i && !fix_seen_r)
        begin
            beep_req = '{1'b1, 1'b1, fpa_pkg::BEEPS_POS_FIX}; // R07
        end
    end

    fpa_beeper #(
        .FAST_CYC(FAST_CYC),
        .NORM_CYC(NORM_CYC)
    ) u_beeper (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .req_i(beep_req),
        .busy_o(),
        .speaker_o(speaker_o)
    );

endmodule // fpa_annunciator

// File: verif/fpa_annunciator_checker.sv
/* Port assertions for the annunciator.
   Assumes one clock, sys_clk_i with rst_i, and ce_i held high. */
`timescale 1ns/1ps
module fpa_annunciator_checker (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Inputs
    input wire logic dc_present_i,
    input wire logic master_power_switch_i,
    input wire logic remote_line_shorted_i,
    input wire logic set_button_i,
    input wire logic alarm_button_i,
    input wire logic transmitting_i,
    input wire logic ant_volt_low_cmd_i,
    input wire logic ant_volt_high_cmd_i,
    input wire logic synced_i,
    input wire logic logged_in_i,
    input wire logic mail_received_i,
    // Outputs
    input wire logic unit_on_o,
    input wire logic ser_default_load_o,
    input wire fpa_pkg::fpa_serial_cfg_type ser_default_cfg_o,
    input wire logic distress_start_o,
    input wire logic ant_supply_tx_o,
    input wire logic ant_supply_rx_high_o,
    input wire logic power_lamp_o,
    input wire fpa_pkg::fpa_lamps_type lamps_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    power_lamp_a: assert property (dc_present_i |=> power_lamp_o)
        else $error("power lamp dark");
    master_off_a: assert property (!master_power_switch_i |=> !unit_on_o)
        else $error("on with master off");
    remote_on_a: assert property (master_power_switch_i && remote_line_shorted_i
        |=> unit_on_o)
        else $error("off with remote on");
    ant_tx_a: assert property (transmitting_i |=> ant_supply_tx_o)
        else $error("no transmit level");
    ant_select_a: assert property (ant_volt_low_cmd_i || ant_volt_high_cmd_i |=> ##1
        ant_supply_rx_high_o == $past(ant_volt_high_cmd_i, 2))
        else $error("wrong receive level");
    login_steady_a: assert property (logged_in_i |=> lamps_o.login)
        else $error("login lamp dark");
    login_dark_a: assert property (!synced_i && !logged_in_i |=> !lamps_o.login)
        else $error("login lamp lit");
    mail_steady_a: assert property (mail_received_i |=> ##1 lamps_o.mail)
        else $error("mail lamp dark");
    ser_values_a: assert property (ser_default_load_o |->
        ser_default_cfg_o == {16'h12c0, 4'h8, 1'b0, 2'h1})
        else $error("bad serial defaults");
    ser_once_a: assert property (ser_default_load_o |-> !$past(unit_on_o, 2))
        else $error("late serial load");
    distress_hold_a: assert property (distress_start_o |->
        $past(set_button_i) && $past(alarm_button_i) ##1 !distress_start_o)
        else $error("start without hold");
endmodule // fpa_annunciator_checker

bind fpa_annunciator fpa_annunciator_checker u_chk (
    .sys_clk_i, .rst_i, .dc_present_i, .master_power_switch_i, .remote_line_shorted_i,
    .set_button_i, .alarm_button_i, .transmitting_i, .ant_volt_low_cmd_i, .ant_volt_high_cmd_i,
    .synced_i, .logged_in_i, .mail_received_i, .unit_on_o, .ser_default_load_o,
    .ser_default_cfg_o, .distress_start_o, .ant_supply_tx_o, .ant_supply_rx_high_o,
    .power_lamp_o, .lamps_o
);

// File: verif/fpa_panel_model.sv
/* Speaker listener on the panel side: counts tones and the length of the last one.
   Assumes clear_i is high for at least one edge before a burst. */
`timescale 1ns/1ps
module fpa_panel_model (
    // Clock and control
    input wire logic sys_clk_i,
    input wire logic clear_i,
    // Speaker
    input wire logic speaker_i,
    output int beeps_o,
    output int tone_len_o
);
    int run;

    always_ff @(posedge sys_clk_i)
    begin
        if (clear_i)
        begin
            beeps_o <= 0;
            run <= 0;
            tone_len_o <= 0;
        end
        else if (speaker_i)
        begin
            run <= run + 1;
            tone_len_o <= run + 1;
            if (run == 0)
                beeps_o <= beeps_o + 1;
        end
        else
            run <= 0;
    end
endmodule // fpa_panel_model

// File: verif/fpa_annunciator_test.sv
/* Self-checking bench for the annunciator, with short timings.
   Assumes the checker binds itself; ce_i is held high. */
`timescale 1ns/1ps
module fpa_annunciator_test;
    localparam int HOLD = 50;
    localparam int FAST = 3;
    localparam int NORM = 6;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic dc = 1'b1, master = 1'b0, remote = 1'b0, set_b = 1'b0, alarm_b = 1'b0;
    logic silent = 1'b0, synced = 1'b0, logged = 1'b0, tx_proto = 1'b0, txing = 1'b0;
    logic mclr = 1'b1, hit;
    // Pulsed inputs, one bit each
    logic [12:0] pl = 13'h0;
    logic [31:0] wake_iv = 32'h0;
    logic unit_on, ser_load, dstart, ant_tx, ant_rxh, plamp, spk;
    fpa_pkg::fpa_serial_cfg_type ser_cfg;
    fpa_pkg::fpa_lamps_type lamps;
    int beeps, tlen, n, err_count = 0, cmp_count = 0;

    initial
    begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    fpa_annunciator #(.HOLD_CYC(HOLD), .BLINK_CYC(4), .FAST_CYC(FAST), .NORM_CYC(NORM)) DUT (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .dc_present_i(dc), .master_power_switch_i(master), .remote_line_shorted_i(remote),
        .sleep_req_i(pl[12]), .wake_interval_i(wake_iv),
        .set_button_i(set_b), .alarm_button_i(alarm_b),
        .egc_urgent_rx_i(pl[0]), .printer_error_i(pl[1]), .print_bell_i(pl[2]),
        .tx_start_i(pl[3]), .distress_ack_i(pl[4]), .pos_fix_i(pl[5]),
        .silent_mode_i(silent), .synced_i(synced), .logged_in_i(logged),
        .tx_protocol_i(tx_proto), .transmitting_i(txing), .land_earth_station_ack_i(pl[6]),
        .mail_incoming_i(pl[7]), .mail_received_i(pl[8]), .mail_read_i(pl[9]),
        .ant_volt_low_cmd_i(pl[10]), .ant_volt_high_cmd_i(pl[11]),
        .unit_on_o(unit_on), .ser_default_load_o(ser_load), .ser_default_cfg_o(ser_cfg),
        .distress_start_o(dstart), .ant_supply_tx_o(ant_tx), .ant_supply_rx_high_o(ant_rxh),
        .power_lamp_o(plamp), .lamps_o(lamps), .speaker_o(spk)
    );

    fpa_panel_model u_panel (
        .sys_clk_i(sys_clk_i), .clear_i(mclr), .speaker_i(spk), .beeps_o(beeps), .tone_len_o(tlen)
    );

    // ----------------
    // Tasks
    // ----------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("compares %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk_i);
    endtask

    task automatic pulse(input int idx);
        pl[idx] = 1'b1;
        cyc(1);
        pl = 13'h0;
    endtask

    // One event, then count the whole burst
    task automatic beep(input int idx, input int cnt, input int len);
        mclr = 1'b1;
        cyc(1);
        mclr = 1'b0;
        pulse(idx);
        cyc(40);
        check(beeps, cnt);
        check(tlen, len);
    endtask

    // Twelve samples span one and a half blink periods
    task automatic lamp(input int idx, input int mode);
        int ones = 0;
        repeat (12)
        begin
            cyc(1);
            ones += lamps[idx];
        end
        check((ones == 0) ? 0 : (ones == 12) ? 1 : 2, mode);
    endtask

    task automatic watch(input int k);
        hit = 1'b0;
        repeat (k)
        begin
            cyc(1);
            hit |= ser_load;
        end
    endtask

    // ----------------
    // Main sequence
    // ----------------
    initial
    begin
        cyc(3);
        rst_i = 1'b0;
        check(unit_on, 0);
        check(ant_rxh, 1);
        check(lamps, 0);
        set_b = 1'b1;
        master = 1'b1;
        remote = 1'b1;
        watch(4);
        check(hit, 1);
        check(ser_cfg, {16'h12c0, 4'h8, 1'b0, 2'h1});
        set_b = 1'b0;
        cyc(2);
        set_b = 1'b1;
        watch(6);
        check(hit, 0);
        mclr = 1'b1;
        cyc(1);
        mclr = 1'b0;
        alarm_b = 1'b1;
        for (n = 0; n < HOLD + 10 && dstart !== 1'b1; n++)
            cyc(1);
        check(n >= HOLD - 2 && n <= HOLD + 4, 1);
        if (n >= HOLD + 10)
            results();
        lamp(0, 2);
        set_b = 1'b0;
        alarm_b = 1'b0;
        cyc(20);
        check(beeps, 1);
        check(tlen, NORM);
        beep(4, 1, NORM);
        lamp(0, 1);
        beep(0, 4, FAST);
        beep(1, 2, NORM);
        beep(2, 1, NORM);
        beep(3, 1, NORM);
        beep(5, 2, FAST);
        beep(5, 0, 0);
        silent = 1'b1;
        beep(3, 0, 0);
        beep(4, 0, 0);
        synced = 1'b1;
        lamp(3, 2);
        logged = 1'b1;
        lamp(3, 1);
        synced = 1'b0;
        logged = 1'b0;
        lamp(3, 0);
        tx_proto = 1'b1;
        lamp(2, 2);
        tx_proto = 1'b0;
        txing = 1'b1;
        lamp(2, 1);
        check(ant_tx, 1);
        txing = 1'b0;
        lamp(2, 2);
        check(ant_tx, 0);
        pulse(6);
        lamp(2, 0);
        pulse(7);
        lamp(1, 2);
        pulse(8);
        lamp(1, 1);
        pulse(9);
        lamp(1, 0);
        pulse(10);
        cyc(1);
        check(ant_rxh, 0);
        pl = 13'h0c00;
        cyc(1);
        pl = 13'h0;
        cyc(1);
        check(ant_rxh, 1);
        dc = 1'b0;
        cyc(2);
        check(plamp, 0);
        dc = 1'b1;
        cyc(2);
        check(plamp, 1);
        for (int i = 0; i < 4; i++)
        begin
            master = i[1];
            remote = i[0];
            cyc(2);
            check(unit_on, i == 3);
        end
        remote = 1'b0;
        wake_iv = 32'h14;
        pulse(12);
        for (n = 0; n < 40 && unit_on !== 1'b1; n++)
            cyc(1);
        check(n >= 17 && n <= 24, 1);
        master = 1'b0;
        cyc(2);
        check(unit_on, 0);
        results();
    end
endmodule // fpa_annunciator_test
